// ---- common/drd_map.vh ----
// Purpose: Constants for the dual-rank DDR SDRAM access block
// Assumes: Included by the design file by its bare name
// Notes:   Register offsets are byte addresses on the Wishbone slave
`ifndef DRD_MAP_VH
`define DRD_MAP_VH
`define DRD_REG_CTRL   4'h0
`define DRD_REG_STAT   4'h4
`define DRD_CTRL_W     4
`define DRD_CTRL_RESET 4'h2
`define DRD_CTRL_ILV   0
`define DRD_CTRL_TERM  1
`define DRD_STAT_RD    16
`define DRD_STAT_WR    17
`define DRD_CMD_ACT    3'b011
`define DRD_CMD_RD     3'b101
`define DRD_CMD_WR     3'b100
`define DRD_CMD_PRE    3'b010
`define DRD_BEATS      4'h8
`define DRD_LAST_BEAT  4'h7
`define DRD_PRE_ALL    10
`endif

// ---- src/drd_sdram.v ----
// What this block does
// - Two data words per clock, both phases
// - One eight-word core transfer per access
// - Device drives strobe edge-aligned with read data
// - Bursts walk a fixed eight beats in programmed order
// - Activate bank and address pick opened row
// - Read/write picks rank, bank, start column
// - Rank decodes commands only while selected
// - Masked write beats are discarded
// - Termination follows registered control when enabled
//
// Purpose: Behavioural two-rank DDR SDRAM core sampled on a fast system clock
// Assumes: Memory clock is at least eight times slower than ref_clk
// Notes:   All pin inputs share one two-stage synchroniser so their skew is kept
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "drd_map.vh"

module drd_fifo #(
    parameter WIDTH = 4,
    parameter DEPTH = 8,
    parameter PTR_W = 3
) (
    input  wire             ref_clk,
    input  wire             reset_n,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);
    localparam [PTR_W:0] FULL = DEPTH;
    reg  [WIDTH-1:0] store [0:DEPTH-1];
    reg  [PTR_W-1:0] wrPtrQ;
    reg  [PTR_W-1:0] rdPtrQ;
    reg  [PTR_W:0]   countQ;
    wire             push;
    wire             pop;

    assign inReady  = (countQ != FULL);
    assign outValid = (countQ != {(PTR_W+1){1'b0}});
    assign outData  = store[rdPtrQ];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    always @(posedge ref_clk) begin
        if (!reset_n) begin
            wrPtrQ <= {PTR_W{1'b0}};
            rdPtrQ <= {PTR_W{1'b0}};
            countQ <= {(PTR_W+1){1'b0}};
        end else begin
            if (push) begin
                store[wrPtrQ] <= inData;
                wrPtrQ        <= wrPtrQ + 1'b1;
            end
            if (pop)
                rdPtrQ <= rdPtrQ + 1'b1;
            if (push & ~pop)
                countQ <= countQ + 1'b1;
            else if (pop & ~push)
                countQ <= countQ - 1'b1;
        end
    end
endmodule // drd_fifo

module drd_sdram #(
    parameter DQ_W     = 4,
    parameter ADDR_W   = 14,
    parameter ROW_W    = 4,
    parameter COL_W    = 6,
    parameter READ_LAT = 2
) (
    input  wire              ref_clk,
    input  wire              reset_n,
    input  wire              memClk,
    input  wire [1:0]        rankSelN,
    input  wire              rowStrobeN,
    input  wire              colStrobeN,
    input  wire              writeEnN,
    input  wire [2:0]        bankAddr,
    input  wire [ADDR_W-1:0] addr,
    input  wire [1:0]        clkEnable,
    input  wire [1:0]        termination_control,
    input  wire              write_mask,
    input  wire [DQ_W-1:0]   dqIn,
    output reg  [DQ_W-1:0]   dqOut,
    output reg               dqOe,
    input  wire              dqsIn,
    output reg               dqsOut,
    output reg               dqsNOut,
    output reg               dqsOe,
    output reg  [1:0]        termOn,
    input  wire              wb_cyc_i,
    input  wire              wb_stb_i,
    input  wire              wb_we_i,
    input  wire [3:0]        wb_adr_i,
    input  wire [3:0]        wb_sel_i,
    input  wire [31:0]       wb_dat_i,
    output reg  [31:0]       wb_dat_o,
    output reg               wb_ack_o
);
    localparam CW    = COL_W - 3;
    localparam IW    = 4 + ROW_W + CW;
    localparam DEPTH = 1 << IW;
    // Clock, selects, command, bank, enables, terminations, strobe, mask: 15 bits
    localparam SW    = 15 + ADDR_W + DQ_W;
    localparam [7:0] LAT_INIT = READ_LAT;
    localparam [1:0] RS_IDLE = 2'd0, RS_WAIT = 2'd1, RS_DRIVE = 2'd2;
    localparam [1:0] WS_IDLE = 2'd0, WS_CAP = 2'd1, WS_COMMIT = 2'd2;

    reg  [8*DQ_W-1:0] core [0:DEPTH-1];
    reg  [ROW_W-1:0]  rowQ [0:15];
    reg  [15:0]       openQ;
    reg  [SW-1:0]     pinS1;
    reg  [SW-1:0]     pinS2;
    reg               ckS3;
    reg               dqsS3;
    reg  [`DRD_CTRL_W-1:0] ctrlQ;
    reg  [1:0]        rStateQ;
    reg  [1:0]        wStateQ;
    reg  [8*DQ_W-1:0] pfQ;
    reg  [2:0]        rStartQ;
    reg  [3:0]        fillQ;
    reg  [3:0]        beatQ;
    reg  [7:0]        latQ;
    reg  [IW-1:0]     wIdxQ;
    reg  [2:0]        wStartQ;
    reg  [3:0]        wBeatQ;
    reg  [8*DQ_W-1:0] wDataQ;
    reg  [7:0]        wMaskQ;
    reg  [8*DQ_W-1:0] merged;
    integer           i;
    integer           j;

    wire              ckS;
    wire [1:0]        csS;
    wire [2:0]        cmdS;
    wire [2:0]        baS;
    wire [ADDR_W-1:0] adS;
    wire [1:0]        ckeS;
    wire [1:0]        odtS;
    wire              dqsS;
    wire              dmS;
    wire [DQ_W-1:0]   dqS;
    assign {ckS, csS, cmdS, baS, adS, ckeS, odtS, dqsS, dmS, dqS} = pinS2;

    wire ckRise  = ckS & ~ckS3;
    wire ckEdge  = ckS ^ ckS3;
    wire dqsEdge = dqsS ^ dqsS3;
    wire ilv     = ctrlQ[`DRD_CTRL_ILV];

    // Burst order: sequential wraps within the eight, interleaved xors the start
    function [2:0] beatPos;
        input [2:0] start;
        input [2:0] n;
        input       inter;
        begin
            beatPos = inter ? (start ^ n) : (start + n);
        end
    endfunction

    wire       cmdRank  = csS[0];
    wire       cmdValid = ckRise & ~csS[cmdRank] & ckeS[cmdRank];
    wire [3:0] bk       = {cmdRank, baS};
    wire       idle     = (rStateQ == RS_IDLE) & (wStateQ == WS_IDLE);
    // Accesses to a closed bank are dropped silently
    wire       bankOk   = openQ[bk] & idle;
    wire       rdGo     = cmdValid & (cmdS == `DRD_CMD_RD) & bankOk;
    wire       wrGo     = cmdValid & (cmdS == `DRD_CMD_WR) & bankOk;
    wire [IW-1:0] idx   = {bk, rowQ[bk], adS[COL_W-1:3]};

    wire            fifoInValid = (rStateQ != RS_IDLE) & (fillQ != `DRD_BEATS);
    wire            fifoInReady;
    wire            fifoOutValid;
    wire [DQ_W-1:0] fifoOutData;
    wire [2:0]      fillPos = beatPos(rStartQ, fillQ[2:0], ilv);
    wire            popNow  = fifoOutValid &
                              (((rStateQ == RS_WAIT) & ckRise & (latQ == 8'h00)) |
                               ((rStateQ == RS_DRIVE) & ckEdge & (beatQ != `DRD_BEATS)));

    drd_fifo #(.WIDTH(DQ_W), .DEPTH(8), .PTR_W(3)) readFifo (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .inData   (pfQ[fillPos*DQ_W +: DQ_W]),
        .outValid (fifoOutValid),
        .outReady (popNow),
        .outData  (fifoOutData)
    );

    always @(posedge ref_clk) begin
        if (!reset_n) begin
            pinS1 <= {SW{1'b0}};
            pinS2 <= {SW{1'b0}};
            ckS3  <= 1'b0;
            dqsS3 <= 1'b0;
        end else begin
            pinS1 <= {memClk, rankSelN, rowStrobeN, colStrobeN, writeEnN, bankAddr, addr,
                      clkEnable, termination_control, dqsIn, write_mask, dqIn};
            pinS2 <= pinS1;
            ckS3  <= pinS2[SW-1];
            dqsS3 <= pinS2[DQ_W+1];
        end
    end

    // Bank state per rank; precharge with the all-banks bit closes the whole rank
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            openQ <= 16'h0000;
            for (i = 0; i < 16; i = i + 1)
                rowQ[i] <= {ROW_W{1'b0}};
        end else if (cmdValid & (cmdS == `DRD_CMD_ACT)) begin
            openQ[bk] <= 1'b1;
            rowQ[bk]  <= adS[ROW_W-1:0];
        end else if (cmdValid & (cmdS == `DRD_CMD_PRE)) begin
            for (i = 0; i < 16; i = i + 1)
                if ((i / 8 == cmdRank) & (adS[`DRD_PRE_ALL] | (i % 8 == baS)))
                    openQ[i] <= 1'b0;
        end
    end

    // Read: whole burst leaves the core in one cycle, then streams out through the fifo
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            rStateQ <= RS_IDLE;
            pfQ     <= {8*DQ_W{1'b0}};
            rStartQ <= 3'd0;
            fillQ   <= 4'h0;
            beatQ   <= 4'h0;
            latQ    <= 8'h00;
            dqOut   <= {DQ_W{1'b0}};
            dqOe    <= 1'b0;
            dqsOut  <= 1'b0;
            dqsNOut <= 1'b1;
            dqsOe   <= 1'b0;
        end else begin
            if (fifoInValid & fifoInReady)
                fillQ <= fillQ + 1'b1;
            if (popNow) begin
                dqOut   <= fifoOutData;
                dqsOut  <= ckRise;
                dqsNOut <= ~ckRise;
                dqOe    <= 1'b1;
                dqsOe   <= 1'b1;
                beatQ   <= beatQ + 1'b1;
                rStateQ <= RS_DRIVE;
            end
            case (rStateQ)
                RS_IDLE: begin
                    if (rdGo) begin
                        pfQ     <= core[idx];
                        rStartQ <= adS[2:0];
                        fillQ   <= 4'h0;
                        beatQ   <= 4'h0;
                        latQ    <= LAT_INIT;
                        rStateQ <= RS_WAIT;
                    end
                end
                RS_WAIT: begin
                    if (ckRise & (latQ != 8'h00))
                        latQ <= latQ - 8'h01;
                end
                RS_DRIVE: begin
                    if (ckRise & (beatQ == `DRD_BEATS)) begin
                        dqOe    <= 1'b0;
                        dqsOe   <= 1'b0;
                        dqsOut  <= 1'b0;
                        dqsNOut <= 1'b1;
                        rStateQ <= RS_IDLE;
                    end
                end
                default: rStateQ <= RS_IDLE;
            endcase
        end
    end

    always @* begin
        merged = core[wIdxQ];
        for (j = 0; j < 8; j = j + 1)
            if (!wMaskQ[j])
                merged[j*DQ_W +: DQ_W] = wDataQ[j*DQ_W +: DQ_W];
    end

    // Write: beats are caught on every edge of the controller's strobe
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            wStateQ <= WS_IDLE;
            wIdxQ   <= {IW{1'b0}};
            wStartQ <= 3'd0;
            wBeatQ  <= 4'h0;
            wDataQ  <= {8*DQ_W{1'b0}};
            wMaskQ  <= 8'hff;
        end else begin
            case (wStateQ)
                WS_IDLE: begin
                    if (wrGo) begin
                        wIdxQ   <= idx;
                        wStartQ <= adS[2:0];
                        wBeatQ  <= 4'h0;
                        wMaskQ  <= 8'hff;
                        wStateQ <= WS_CAP;
                    end
                end
                WS_CAP: begin
                    if (dqsEdge) begin
                        wDataQ[beatPos(wStartQ, wBeatQ[2:0], ilv)*DQ_W +: DQ_W] <= dqS;
                        wMaskQ[beatPos(wStartQ, wBeatQ[2:0], ilv)] <= dmS;
                        wBeatQ <= wBeatQ + 1'b1;
                        if (wBeatQ == `DRD_LAST_BEAT)
                            wStateQ <= WS_COMMIT;
                    end
                end
                WS_COMMIT: begin
                    core[wIdxQ] <= merged;
                    wStateQ     <= WS_IDLE;
                end
                default: wStateQ <= WS_IDLE;
            endcase
        end
    end

    always @(posedge ref_clk) begin
        if (!reset_n)
            termOn <= 2'b00;
        else if (ckRise)
            termOn <= odtS & {2{ctrlQ[`DRD_CTRL_TERM]}};
    end

    // Wishbone slave: one wait state, unmapped reads return zero
    wire wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            ctrlQ    <= `DRD_CTRL_RESET;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wbReq;
            if (wbReq & wb_we_i & wb_sel_i[0] & (wb_adr_i == `DRD_REG_CTRL))
                ctrlQ <= wb_dat_i[`DRD_CTRL_W-1:0];
            if (wbReq & ~wb_we_i) begin
                if (wb_adr_i == `DRD_REG_CTRL)
                    wb_dat_o <= {{(32-`DRD_CTRL_W){1'b0}}, ctrlQ};
                else if (wb_adr_i == `DRD_REG_STAT)
                    wb_dat_o <= {14'h0000, wStateQ != WS_IDLE, rStateQ != RS_IDLE, openQ};
                else
                    wb_dat_o <= 32'h00000000;
            end
        end
    end
endmodule // drd_sdram

// ---- testbench/drd_ctrl_model.sv ----
// Purpose: Memory controller model driving the link pins
// Assumes: Commands change on the falling memory clock edge
// Notes:   Link clock runs free, as a command clock does
`timescale 1ns/1ps
module drd_ctrl_model #(
    parameter READ_LAT = 2
) (
    output reg        memClk,
    output reg  [1:0] rankSelN,
    output reg        rowStrobeN,
    output reg        colStrobeN,
    output reg        writeEnN,
    output reg  [2:0] bankAddr,
    output reg [13:0] addr,
    output reg        write_mask,
    output reg  [3:0] ctrlDq,
    output reg        ctrlDqs,
    input  wire [3:0] dqLine,
    input  wire       dqsLine
);
    initial begin
        memClk = 1'b0;
        {rankSelN, rowStrobeN, colStrobeN, writeEnN} = 5'h1f;
        bankAddr = 3'h0;
        addr = 14'h0;
        write_mask = 1'b0;
        ctrlDq = 4'h0;
        ctrlDqs = 1'b0;
        #7;
        forever #160 memClk = ~memClk;
    end
    // Held across one rising edge; released bus shows the inverse
    task automatic cmd(input [1:0] s, input [2:0] c, input [2:0] b, input [13:0] a);
        @(negedge memClk);
        {rankSelN, rowStrobeN, colStrobeN, writeEnN} = {s, c};
        bankAddr = b;
        addr = a;
        @(negedge memClk);
        {rankSelN, rowStrobeN, colStrobeN, writeEnN} = 5'h1f;
        bankAddr = ~b;
        addr = ~a;
    endtask
    task automatic wr(input [1:0] s, input [2:0] b, input [5:0] col, input [31:0] d,
                      input [7:0] m);
        integer k;
        cmd(s, 3'b100, b, {8'h00, col});
        for (k = 0; k < 8; k = k + 1) begin
            ctrlDq = d[4*k +: 4];
            write_mask = m[k];
            #80 ctrlDqs = ~ctrlDqs; // Edge centred in the beat
            @(memClk);
        end
        ctrlDq = ~ctrlDq;
        write_mask = ~write_mask;
    endtask
    // Samples mid-beat, half a period after each edge-aligned change
    task automatic rd(input [1:0] s, input [2:0] b, input [5:0] col, output [31:0] d,
                      output [7:0] q);
        integer k;
        cmd(s, 3'b101, b, {8'h00, col});
        repeat (2 * READ_LAT + 2) @(memClk);
        for (k = 0; k < 8; k = k + 1) begin
            d[4*k +: 4] = dqLine;
            q[k] = dqsLine;
            @(memClk);
        end
    endtask
endmodule // drd_ctrl_model

// ---- testbench/drd_sdram_asserts.sv ----
// Purpose: Checker on the device pins and Wishbone slave
// Assumes: memClk edges never meet ref_clk edges
// Notes:   Bound from the testbench top
`timescale 1ns/1ps
module drd_sdram_asserts (
    input wire       ref_clk,
    input wire       reset_n,
    input wire [1:0] termination_control,
    input wire [3:0] dqOut,
    input wire       dqOe,
    input wire       dqsOut,
    input wire       dqsNOut,
    input wire       dqsOe,
    input wire [1:0] termOn,
    input wire       wb_cyc_i,
    input wire       wb_stb_i,
    input wire       wb_ack_o
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    a_term_follow: assert property ($rose(termOn[0]) |-> $past(termination_control[0], 3))
        else $error("termination on without request");
    a_strobe_pair: assert property (dqsOe |-> dqsNOut == !dqsOut)
        else $error("strobe pair not complementary");
    a_oe_pair: assert property (dqOe == dqsOe)
        else $error("data and strobe enables differ");
    a_burst_span: assert property ($rose(dqOe) |-> dqOe[*8] ##[22:26] $fell(dqOe))
        else $error("read burst length wrong");
    a_beat_hold: assert property (dqsOe && $changed(dqsOut) |=> ($stable(dqOut) && $stable(dqsOut))[*3])
        else $error("read beat shorter than half a memory clock");
    cover property ($rose(dqOe));
    cover property ($rose(termOn[1]));
    cover property (wb_ack_o);
endmodule // drd_sdram_asserts

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench for the dual-rank device core
// Assumes: Default parameters, read latency of 2
// Notes:   Memory words are read and written as eight nibbles
`timescale 1ns/1ps
`include "drd_map.vh"
module testbench;
    reg         ref_clk = 1'b0;
    reg         reset_n = 1'b0;
    reg  [1:0]  tc = 2'b00;
    reg  [1:0]  cke = 2'b11;
    reg         cyc = 1'b0;
    reg         stb = 1'b0;
    reg         we = 1'b0;
    reg  [3:0]  adr = 4'h0;
    reg  [3:0]  sel = 4'h0;
    reg  [31:0] wd = 32'h0;
    reg  [31:0] rd;
    reg  [31:0] md;
    reg  [7:0]  st;
    integer     fails = 0;
    integer     checks = 0;
    wire [31:0] wbDat;
    wire        ack, mClk, ras, cas, wen, wm, dqOe, dqsOut, dqsNOut, dqsOe, cDqs;
    wire [1:0]  cs, termOn;
    wire [2:0]  ba;
    wire [13:0] a;
    wire [3:0]  dqOut, cDq;
    wire [3:0]  dqLine = dqOe ? dqOut : cDq;
    wire        dqsLine = dqsOe ? dqsOut : cDqs;
    always #20 ref_clk = ~ref_clk;
    drd_sdram drd_sdram_inst (.ref_clk(ref_clk), .reset_n(reset_n), .memClk(mClk),
        .rankSelN(cs), .rowStrobeN(ras), .colStrobeN(cas), .writeEnN(wen), .bankAddr(ba),
        .addr(a), .clkEnable(cke), .termination_control(tc), .write_mask(wm),
        .dqIn(dqLine), .dqOut(dqOut), .dqOe(dqOe), .dqsIn(dqsLine), .dqsOut(dqsOut),
        .dqsNOut(dqsNOut), .dqsOe(dqsOe), .termOn(termOn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(wbDat),
        .wb_ack_o(ack));
    drd_ctrl_model drd_ctrl_model_inst (.memClk(mClk), .rankSelN(cs), .rowStrobeN(ras),
        .colStrobeN(cas), .writeEnN(wen), .bankAddr(ba), .addr(a), .write_mask(wm),
        .ctrlDq(cDq), .ctrlDqs(cDqs), .dqLine(dqLine), .dqsLine(dqsLine));
    task automatic chk(input string nm, input [31:0] e, input [31:0] g);
        checks = checks + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("unexpected %0s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input w, input [3:0] ad, input [3:0] s, input [31:0] d);
        integer n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        sel <= s;
        wd <= d;
        do begin
            @(posedge ref_clk);
            n = n + 1;
        end while (ack !== 1'b1 && n < 20);
        if (n == 20) fails = fails + 1;
        rd = wbDat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge ref_clk);
    endtask
    task end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #400000;
        fails = fails + 1;
        end_sim;
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        wb(1'b0, `DRD_REG_CTRL, 4'hf, 32'h0);
        chk("ctrl reset", {28'h0, `DRD_CTRL_RESET}, rd);
        wb(1'b1, `DRD_REG_CTRL, 4'hf, 32'he);
        wb(1'b1, `DRD_REG_CTRL, 4'he, 32'h1);
        wb(1'b1, 4'h8, 4'hf, 32'h1);
        wb(1'b0, `DRD_REG_CTRL, 4'hf, 32'h0);
        chk("ctrl", 32'he, rd);
        wb(1'b0, 4'h8, 4'hf, 32'h0);
        chk("unmapped", 32'h0, rd);
        tc <= 2'b01;
        repeat (30) @(posedge ref_clk);
        chk("termOn", 32'h1, {30'h0, termOn});
        wb(1'b1, `DRD_REG_CTRL, 4'hf, 32'hc);
        tc <= 2'b10;
        repeat (30) @(posedge ref_clk);
        chk("termOn off", 32'h0, {30'h0, termOn});
        wb(1'b1, `DRD_REG_CTRL, 4'hf, 32'h2);
        repeat (30) @(posedge ref_clk);
        chk("termOn rank1", 32'h2, {30'h0, termOn});
        drd_ctrl_model_inst.cmd(2'b10, `DRD_CMD_ACT, 3'h3, 14'h5);
        wb(1'b0, `DRD_REG_STAT, 4'hf, 32'h0);
        chk("open banks", 32'h8, rd);
        drd_ctrl_model_inst.wr(2'b10, 3'h3, 6'h0, 32'h76543210, 8'h00);
        drd_ctrl_model_inst.rd(2'b10, 3'h3, 6'h0, md, st);
        chk("burst", 32'h76543210, md);
        chk("strobe", 32'h55, {24'h0, st});
        drd_ctrl_model_inst.rd(2'b10, 3'h3, 6'h2, md, st);
        chk("sequential", 32'h10765432, md);
        wb(1'b1, `DRD_REG_CTRL, 4'hf, 32'h3);
        drd_ctrl_model_inst.rd(2'b10, 3'h3, 6'h2, md, st);
        chk("interleaved", 32'h54761032, md);
        wb(1'b1, `DRD_REG_CTRL, 4'hf, 32'h2);
        drd_ctrl_model_inst.wr(2'b10, 3'h3, 6'h0, 32'hfedcba98, 8'h0f);
        drd_ctrl_model_inst.cmd(2'b01, `DRD_CMD_ACT, 3'h3, 14'h5);
        drd_ctrl_model_inst.wr(2'b01, 3'h3, 6'h0, 32'h89abcdef, 8'h00);
        drd_ctrl_model_inst.wr(2'b11, 3'h3, 6'h0, 32'h0, 8'h00);
        wb(1'b0, `DRD_REG_STAT, 4'hf, 32'h0);
        chk("open banks", 32'h808, rd);
        drd_ctrl_model_inst.rd(2'b10, 3'h3, 6'h0, md, st);
        chk("masked", 32'hfedc3210, md);
        drd_ctrl_model_inst.rd(2'b01, 3'h3, 6'h0, md, st);
        chk("rank1", 32'h89abcdef, md);
        drd_ctrl_model_inst.cmd(2'b10, `DRD_CMD_PRE, 3'h0, 14'h0400);
        wb(1'b0, `DRD_REG_STAT, 4'hf, 32'h0);
        chk("after close", 32'h800, rd);
        drd_ctrl_model_inst.rd(2'b10, 3'h3, 6'h0, md, st);
        chk("closed strobe", 32'h0, {24'h0, st});
        cke <= 2'b01;
        drd_ctrl_model_inst.cmd(2'b01, `DRD_CMD_PRE, 3'h3, 14'h0000);
        drd_ctrl_model_inst.cmd(2'b00, 3'b001, 3'h0, 14'h0400);
        wb(1'b0, `DRD_REG_STAT, 4'hf, 32'h0);
        chk("cke gated", 32'h800, rd);
        end_sim;
    end
endmodule // testbench
bind drd_sdram drd_sdram_asserts drd_sdram_asserts_inst (.ref_clk(ref_clk),
    .reset_n(reset_n), .termination_control(termination_control), .dqOut(dqOut),
    .dqOe(dqOe), .dqsOut(dqsOut), .dqsNOut(dqsNOut), .dqsOe(dqsOe), .termOn(termOn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
